// ### include/hcp_regs.vh
// Purpose: constants for the host processor port
// Assumes: one 200 MHz clock, host pins synchronous to it
// Notes: definitions only
`ifndef HCP_REGS_VH
`define HCP_REGS_VH

`define HCP_ADDR_W 20
`define HCP_DATA_W 16
`define HCP_NSRC 8
// internal access latency in clock cycles
`define HCP_ACC_LAT 4'h3
// cycles the acknowledge is driven high before release (pseudo open drain)
`define HCP_ACK_RELEASE 2'h1

`endif

// ### tb/hcp_mem_model.sv
// Purpose: memory side answering access requests
// Assumes: request held until done
// Notes: latency set by the bench
`timescale 1ns/1ps
`default_nettype none
module hcp_mem_model (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic [7:0] i_lat,
    input wire logic i_req,
    input wire logic [20:1] i_addr,
    output logic o_done,
    output logic [15:0] o_int_rdata,
    output logic [15:0] o_ext_rdata
);
    logic [7:0] cnt_ff;
    logic done_ff;
    wire [15:0] iv = i_addr[16:1] ^ 16'h1234;
    wire [15:0] ev = i_addr[16:1] ^ 16'h4321;
    // inverted off the done cycle so a late sample never matches
    assign o_int_rdata = done_ff ? iv : ~iv;
    assign o_ext_rdata = done_ff ? ev : ~ev;
    assign o_done = done_ff;
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_ff <= 8'h00;
            done_ff <= 1'b0;
        end else begin
            done_ff <= i_req && cnt_ff == i_lat;
            if (!i_req)
                cnt_ff <= 8'h00;
            else if (cnt_ff != 8'hff)
                cnt_ff <= (cnt_ff == i_lat) ? 8'hff : cnt_ff + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ### tb/hcp_port_checker.sv
// Purpose: pin-level assertions for hcp_port
// Assumes: strap stays put between resets
// Notes: bound to every hcp_port below
`timescale 1ns/1ps
`default_nettype none
module hcp_port_checker #(
    parameter AW = 20,
    parameter DW = 16,
    parameter NSRC = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_sep_strobe_mode,
    input wire logic i_cs_n,
    input wire logic i_write_pin,
    input wire logic i_external_memory_steer,
    input wire logic [AW:1] i_addr,
    input wire logic [DW-1:0] i_data,
    input wire logic o_transfer_acknowledge,
    input wire logic o_transfer_acknowledge_oe,
    input wire logic o_interrupt_request_n,
    input wire logic o_interrupt_request_oe,
    input wire logic [NSRC-1:0] i_src,
    input wire logic [NSRC-1:0] i_src_en,
    input wire logic o_int_req,
    input wire logic o_ext_req,
    input wire logic o_acc_wr,
    input wire logic [AW:1] o_acc_addr,
    input wire logic [DW-1:0] o_acc_wdata
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    wire req = o_int_req | o_ext_req;
    wire [NSRC-1:0] act = i_src & i_src_en;
    cs_gate_a: assert property ($rose(req) |-> !$past(i_cs_n))
        else $error("request without select");
    dir_sel_a: assert property (
        $rose(req) |-> o_acc_wr == !$past(i_write_pin))
        else $error("wrong direction");
    steer_sel_a: assert property (
        $rose(req) |-> o_ext_req == $past(i_external_memory_steer))
        else $error("wrong memory side");
    addr_cap_a: assert property (
        $rose(req) |-> o_acc_addr == $past(i_addr))
        else $error("address not captured");
    wdata_cap_a: assert property (
        $rose(req) && o_acc_wr |-> o_acc_wdata == $past(i_data))
        else $error("write word not captured");
    rdy_hiz_a: assert property (
        i_sep_strobe_mode && i_cs_n && $past(i_cs_n)
        |-> !o_transfer_acknowledge_oe)
        else $error("ready driven while deselected");
    ack_od_a: assert property (
        !i_sep_strobe_mode && o_transfer_acknowledge_oe &&
        o_transfer_acknowledge |=> !o_transfer_acknowledge_oe)
        else $error("acknowledge driven high too long");
    irq_od_a: assert property (
        o_interrupt_request_oe |-> !o_interrupt_request_n)
        else $error("interrupt driven high");
    irq_off_a: assert property (
        (act == 0) [*3] |-> !o_interrupt_request_oe)
        else $error("interrupt without enabled source");
    irq_on_a: assert property (
        (|act) [*3] |-> o_interrupt_request_oe)
        else $error("interrupt missing");
endmodule
bind hcp_port hcp_port_checker #(.AW(AW), .DW(DW), .NSRC(NSRC)) chk_u (.*);
`default_nettype wire

// ### tb/tb_top.sv
// Purpose: self-checking bench for hcp_port
// Assumes: 200 MHz clock
// Notes: memory side modelled by hcp_mem_model
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    logic clk = 0, nrst = 0, strap = 1, cs_n = 1, wr_p = 1, ds = 1, ext = 0;
    logic [20:1] addr = 0;
    logic [15:0] wdat = 0;
    logic [7:0] src = 0, en = 0, lat = 0;
    wire [15:0] o_data, int_rd, ext_rd, acc_wdata;
    wire [20:1] acc_addr;
    wire data_oe, ack, ack_oe, irq_n, irq_oe, int_req, ext_req, acc_wr, done;
    int fails = 0, check_count = 0, cyc = 0;
    hcp_port dut_u (.i_clk_sys(clk), .i_nrst(nrst), .i_sep_strobe_mode(strap),
        .i_cs_n(cs_n), .i_write_pin(wr_p), .i_read_or_data_strobe(ds),
        .i_external_memory_steer(ext), .i_addr(addr), .i_data(wdat),
        .o_data(o_data), .o_data_oe(data_oe), .o_transfer_acknowledge(ack),
        .o_transfer_acknowledge_oe(ack_oe), .o_interrupt_request_n(irq_n),
        .o_interrupt_request_oe(irq_oe), .i_src(src), .i_src_en(en),
        .o_int_req(int_req), .o_ext_req(ext_req), .o_acc_wr(acc_wr),
        .o_acc_addr(acc_addr), .o_acc_wdata(acc_wdata), .i_acc_done(done),
        .i_int_rdata(int_rd), .i_ext_rdata(ext_rd));
    hcp_mem_model mem_u (.i_clk_sys(clk), .i_nrst(nrst), .i_lat(lat),
        .i_req(int_req | ext_req), .i_addr(acc_addr), .o_done(done),
        .o_int_rdata(int_rd), .o_ext_rdata(ext_rd));
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic do_reset(input logic s);
        @(posedge clk);
        nrst <= 0;
        strap <= s;
        repeat (16) @(posedge clk);
        // reset values: ready released, nothing driven, no request
        `CHK({ack, ack_oe, data_oe, irq_oe, int_req, ext_req}, 6'h20)
        nrst <= 1;
        repeat (2) @(posedge clk);
    endtask
    task automatic xfer(input logic w, e, input logic [20:1] a);
        int n;
        logic [16:0] exp_rd;
        exp_rd = {1'b1, a[16:1] ^ (e ? 16'h4321 : 16'h1234)};
        @(posedge clk);
        cs_n <= 0; ext <= e; addr <= a; wdat <= ~a[16:1];
        wr_p <= !w;
        ds <= strap ? w : 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (!(ack_oe === 1 && ack === strap && !int_req && !ext_req)
            && n < 100);
        `CHK(n < 100, 1'b1)
        `CHK(ack, strap)
        `CHK(acc_addr, a)
        `CHK(acc_wr, w)
        if (w)
            `CHK(acc_wdata, ~a[16:1])
        else
            `CHK({data_oe, o_data}, exp_rd)
        @(posedge clk);
        ds <= 1; wr_p <= 1; cs_n <= 1;
        repeat (3) @(posedge clk);
        #1 `CHK({ack_oe, data_oe}, 2'b00)
    endtask
    task automatic t_access(input logic s);
        do_reset(s);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            lat <= i ? 8'h0c : 8'h00;
            xfer(1'b1, 1'b0, 20'hfffff);
            xfer(1'b0, 1'b0, 20'hfffff);
            xfer(1'b0, 1'b1, 20'h00001);
            xfer(1'b1, 1'b1, 20'h00001);
        end
    endtask
    task automatic t_cs_ignore();
        logic seen;
        seen = 1'b0;
        @(posedge clk);
        ds <= 0; wr_p <= 0;
        repeat (10) begin
            @(posedge clk);
            #1 seen = seen | int_req | ext_req | ack_oe | data_oe;
        end
        `CHK(seen, 1'b0)
        @(posedge clk);
        ds <= 1; wr_p <= 1;
    endtask
    task automatic t_irq();
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            src <= 8'h01 << i;
            en <= ~(8'h01 << i);
            repeat (4) @(posedge clk);
            #1 `CHK(irq_oe, 1'b0)
            @(posedge clk);
            en <= 8'h01 << i;
            repeat (4) @(posedge clk);
            #1 `CHK({irq_oe, irq_n}, 2'b10)
        end
        @(posedge clk);
        src <= 8'h00;
        repeat (4) @(posedge clk);
        #1 `CHK(irq_oe, 1'b0)
    endtask
    initial begin
        do_reset(1'b1);
        t_cs_ignore();
        t_irq();
        t_access(1'b1);
        t_access(1'b0);
        summarize();
    end
endmodule
`default_nettype wire

// ### verilog/hcp_irq.v
// Purpose: gathers service requests into the open-drain interrupt line
// Assumes: sources and enables are levels synchronous to i_clk_sys
// Notes: output enable high means the pin is pulled low
`timescale 1ns/1ps
`default_nettype none
`include "hcp_regs.vh"

module hcp_irq #(
    parameter NSRC = `HCP_NSRC
) (
    input wire i_clk_sys,
    input wire i_nrst,
    input wire [NSRC-1:0] i_src,
    input wire [NSRC-1:0] i_src_en,
    output wire o_irq_oe
);
    reg irq_ff;
    wire nxt_irq;

    // only enabled sources can pull the line
    assign nxt_irq = |(i_src & i_src_en);

    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    // pin driven low only while a request stands, else high impedance
    assign o_irq_oe = irq_ff;
endmodule
`default_nettype wire

// ### verilog/hcp_port.v
// Purpose: 16-bit parallel host processor port with two timing styles
// Assumes: host pins synchronous to i_clk_sys; strap fixed before power-up
// Notes: the internal/external memory side is a simple request/answer pair
//
// Behaviour
// - strap high selects separate strobes, low selects data strobe mode.
// - chip select low addresses the device; cycles ignored while high.
// - write pin is write strobe, or read/write direction in data-strobe mode.
// - read pin is read strobe, or data strobe for both directions.
// - steering input high routes access to external memory, low internal.
// - host presents word address on bits 20 down to 1.
// - every transfer moves a full 16-bit word; no byte access.
// - separate-strobe ready push-pull while selected, else high impedance.
// - data-strobe acknowledge asserted low, driven only as pseudo open drain.
// - interrupt pulled low for pending requests, high impedance otherwise.
// - interrupt asserted only for sources whose enable bits are set.
`timescale 1ns/1ps
`default_nettype none
`include "hcp_regs.vh"

module hcp_port #(
    parameter AW = `HCP_ADDR_W,
    parameter DW = `HCP_DATA_W,
    parameter NSRC = `HCP_NSRC
) (
    input wire i_clk_sys,
    input wire i_nrst,
    input wire i_sep_strobe_mode,
    input wire i_cs_n,
    input wire i_write_pin,
    input wire i_read_or_data_strobe,
    input wire i_external_memory_steer,
    input wire [AW:1] i_addr,
    input wire [DW-1:0] i_data,
    output reg [DW-1:0] o_data,
    output reg o_data_oe,
    output reg o_transfer_acknowledge,
    output reg o_transfer_acknowledge_oe,
    output reg o_interrupt_request_n,
    output reg o_interrupt_request_oe,
    input wire [NSRC-1:0] i_src,
    input wire [NSRC-1:0] i_src_en,
    output reg o_int_req,
    output reg o_ext_req,
    output reg o_acc_wr,
    output reg [AW:1] o_acc_addr,
    output reg [DW-1:0] o_acc_wdata,
    input wire i_acc_done,
    input wire [DW-1:0] i_int_rdata,
    input wire [DW-1:0] i_ext_rdata
);
    // -------------------------------------------------------------
    // state machine
    // -------------------------------------------------------------
    localparam ST_IDLE = 4'b0001;
    localparam ST_BUSY = 4'b0010;
    localparam ST_DONE = 4'b0100;
    localparam ST_REL = 4'b1000;

    reg [3:0] st_ff, nxt_st;
    reg mode_ff;
    reg mode_seen_ff;
    reg ext_ff, nxt_ext;
    reg [1:0] rel_cnt_ff, nxt_rel_cnt;
    reg [DW-1:0] rdata_ff, nxt_rdata;
    wire irq_oe;

    // strap caught once after reset release, never sampled under reset
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            mode_ff <= 1'b0;
            mode_seen_ff <= 1'b0;
        end else if (!mode_seen_ff) begin
            mode_ff <= i_sep_strobe_mode;
            mode_seen_ff <= 1'b1;
        end
    end

    // decode of the shared pins per timing style
    function is_strobe;
        input sep;
        input wr_pin;
        input rd_pin;
        begin
            if (sep) begin
                is_strobe = !wr_pin || !rd_pin;
            end else begin
                is_strobe = !rd_pin;
            end
        end
    endfunction

    function is_write;
        input sep;
        input wr_pin;
        begin
            // data-strobe mode: direction low means write
            is_write = sep ? !wr_pin : !wr_pin;
        end
    endfunction

    wire sel = !i_cs_n && mode_seen_ff;
    wire strobe = sel &&
        is_strobe(mode_ff, i_write_pin, i_read_or_data_strobe);
    wire wr = is_write(mode_ff, i_write_pin);

    always @* begin
        nxt_st = st_ff;
        nxt_ext = ext_ff;
        nxt_rel_cnt = rel_cnt_ff;
        nxt_rdata = rdata_ff;
        case (st_ff)
            ST_IDLE: begin
                if (strobe) begin
                    nxt_ext = i_external_memory_steer;
                    nxt_st = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (i_acc_done) begin
                    nxt_rdata = ext_ff ? i_ext_rdata : i_int_rdata;
                    nxt_st = ST_DONE;
                end
            end
            ST_DONE: begin
                // answer stands until the host drops its strobe
                if (!strobe) begin
                    nxt_rel_cnt = `HCP_ACK_RELEASE;
                    nxt_st = ST_REL;
                end
            end
            ST_REL: begin
                // host relies on a released strobe before the next cycle
                if (rel_cnt_ff == 2'h0) begin
                    nxt_st = ST_IDLE;
                end else begin
                    nxt_rel_cnt = rel_cnt_ff - 2'h1;
                end
            end
            default: begin
                nxt_st = ST_IDLE;
            end
        endcase
    end

    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            st_ff <= ST_IDLE;
            ext_ff <= 1'b0;
            rel_cnt_ff <= 2'h0;
            rdata_ff <= {DW{1'b0}};
        end else begin
            st_ff <= nxt_st;
            ext_ff <= nxt_ext;
            rel_cnt_ff <= nxt_rel_cnt;
            rdata_ff <= nxt_rdata;
        end
    end

    // -------------------------------------------------------------
    // access request toward memory
    // -------------------------------------------------------------
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_int_req <= 1'b0;
            o_ext_req <= 1'b0;
            o_acc_wr <= 1'b0;
            o_acc_addr <= {AW{1'b0}};
            o_acc_wdata <= {DW{1'b0}};
        end else if (st_ff == ST_IDLE && strobe) begin
            o_int_req <= !i_external_memory_steer;
            o_ext_req <= i_external_memory_steer;
            o_acc_wr <= wr;
            o_acc_addr <= i_addr;
            o_acc_wdata <= i_data;
        end else if (st_ff == ST_BUSY && i_acc_done) begin
            o_int_req <= 1'b0;
            o_ext_req <= 1'b0;
        end
    end

    // -------------------------------------------------------------
    // pin drivers
    // -------------------------------------------------------------
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_data <= {DW{1'b0}};
            o_data_oe <= 1'b0;
            o_transfer_acknowledge <= 1'b1;
            o_transfer_acknowledge_oe <= 1'b0;
        end else begin
            o_data <= nxt_rdata;
            o_data_oe <= (nxt_st == ST_DONE) && !o_acc_wr && strobe;
            if (mode_ff) begin
                // ready: push-pull while selected, low while busy
                o_transfer_acknowledge_oe <= sel;
                o_transfer_acknowledge <= !(nxt_st == ST_BUSY ||
                    (st_ff == ST_IDLE && strobe));
            end else begin
                // acknowledge low at done, brief high drive, then released
                o_transfer_acknowledge <= !(nxt_st == ST_DONE);
                // high drive only while the release count runs, so the
                // pull-up owns the line before the next cycle can start
                o_transfer_acknowledge_oe <= (nxt_st == ST_DONE) ||
                    (nxt_st == ST_REL && nxt_rel_cnt != 2'h0);
            end
        end
    end

    hcp_irq #(
        .NSRC(NSRC)
    ) u_irq (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_src(i_src),
        .i_src_en(i_src_en),
        .o_irq_oe(irq_oe)
    );

    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_interrupt_request_n <= 1'b1;
            o_interrupt_request_oe <= 1'b0;
        end else begin
            o_interrupt_request_n <= 1'b0;
            o_interrupt_request_oe <= irq_oe;
        end
    end
endmodule
`default_nettype wire
